// ===== hdl/ecpwm_regs.svh
// Register map, field positions, codes and timing counts of the enhanced compare/PWM unit
// Contract
// - Mode field value 1011 selects special event trigger compare mode.
// - Units one and two trigger when compare pair matches the selected timer.
// - The trigger resets the selected 16-bit timer, one or three.
// - Unit two's trigger also starts a conversion if the converter is enabled.
// - Units three to five treat 1011 as compare with software flag (1010).
// - Unit two's trigger does not set the timer one/three interrupt flag.
// - PWM mode drives up to four outputs A-D with selectable polarity.
// - Output config sits in control bits 7:6, mode/polarity in bits 3:0.
// - PWM control values are double-buffered and load at the period reset.
// - Dead-band delay loads at the duty or period boundary, whichever first.
// - PWM waits for the timer reset before starting, one instruction late; here the pins follow the reset by one pclk.
// - Period is (limit plus 1) times 4 Tosc times the prescale value.
// - After count equals limit: clear timer, set output unless duty 0, copy duty.
// - The timer postscaler never changes the PWM frequency.
// - PWM timer is selectable between timer two and four by select bits.
// - Unit three in quad mode overrides unit four's pin with its D output.
// - Duty is 10 bits: duty register high, control bits 5:4 low, buffered.
// - A duty value beyond the period never clears the output.
`ifndef ECPWM_REGS_SVH
`define ECPWM_REGS_SVH
`define ECPWM_OFF_CTRL      8'h00
`define ECPWM_OFF_DUTY      8'h04
`define ECPWM_OFF_DSLV      8'h08
`define ECPWM_OFF_CMP       8'h0C
`define ECPWM_OFF_DB        8'h10
`define ECPWM_OFF_T2CFG     8'h14
`define ECPWM_OFF_T4CFG     8'h18
`define ECPWM_OFF_TSEL      8'h1C
`define ECPWM_OFF_STAT      8'h20
`define ECPWM_RST_BYTE      8'h00
`define ECPWM_RST_TCFG      15'h0000
`define ECPWM_CTRL_OCFG_LSB 6
`define ECPWM_CTRL_DLO_LSB  4
`define ECPWM_TCFG_PRE_LSB  8
`define ECPWM_TCFG_ON_BIT   10
`define ECPWM_TCFG_POST_LSB 11
`define ECPWM_TSEL_PWM_BIT  0
`define ECPWM_TSEL_CMP_BIT  1
`define ECPWM_STAT_FLAG_BIT 8
`define ECPWM_MODE_SEVT     4'hB
`define ECPWM_MODE_SWINT    4'hA
`define ECPWM_MODE_CSET     4'h8
`define ECPWM_MODE_CCLR     4'h9
`define ECPWM_MODE_PWM      2'h3
`define ECPWM_MODE_CMP      2'h2
`define ECPWM_INSTR_TOSC    4
`define ECPWM_DIV_LAST      2'h3
`define ECPWM_PRE4_LAST     4'h3
`define ECPWM_PRE16_LAST    4'hF
`endif

// ===== hdl/ecpwm_pkg.sv
// Types shared by the enhanced compare/PWM unit
package ecpwm_pkg;
	typedef enum logic [1:0] {
		ECPWM_SINGLE   = 2'h0,
		ECPWM_FULL_FWD = 2'h1,
		ECPWM_HALF     = 2'h2,
		ECPWM_FULL_REV = 2'h3
	} ecpwm_ocfg_e;

	// Both full-bridge codes use all four outputs
	function automatic logic ecpwm_is_quad(input ecpwm_ocfg_e ocfg);
		return ocfg[0];
	endfunction
endpackage

// ===== hdl/ecpwm_tmr_if.sv
// Configuration and status of one period timer
`timescale 1ns/1ps
interface ecpwm_tmr_if;
	logic [7:0] limit;
	logic [1:0] prescale;
	logic       on;
	logic [3:0] postscale;
	logic [7:0] count;
	logic [1:0] sub;
	logic       rollover;
	logic       update_tick;
	modport tmr (input limit, prescale, on, postscale, output count, sub, rollover, update_tick);
	modport ctl (output limit, prescale, on, postscale, input count, sub, rollover, update_tick);
endinterface

// ===== hdl/ecpwm_period_timer.sv
// Eight-bit period timer with prescaler and postscaler
`timescale 1ns/1ps
`include "ecpwm_regs.svh"
module ecpwm_period_timer
	import ecpwm_pkg::*;
(
	input  wire logic      pclk,     // Oscillator clock
	input  wire logic      presetn,  // Async reset, active low
	input  wire logic      instr_en, // One pulse per instruction cycle
	input  wire logic [1:0] ph,      // Phase within the instruction cycle
	ecpwm_tmr_if.tmr       t         // Config in, count out
);
	logic [3:0] pre_ff;
	logic [7:0] cnt_ff;
	logic [3:0] post_ff;
	logic [3:0] pre_last;
	logic       inc;

	assign pre_last = (t.prescale == 2'h0) ? 4'h0 :
	                  (t.prescale == 2'h1) ? `ECPWM_PRE4_LAST : `ECPWM_PRE16_LAST;
	assign inc = instr_en & t.on & (pre_ff == pre_last);
	assign t.rollover = inc & (cnt_ff == t.limit);
	// Postscaler only paces update_tick; rollover never looks at it
	assign t.update_tick = t.rollover & (post_ff == t.postscale);
	assign t.count = cnt_ff;
	assign t.sub = (t.prescale == 2'h0) ? ph :
	               (t.prescale == 2'h1) ? pre_ff[1:0] : pre_ff[3:2];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pre_ff  <= 4'h0;
			cnt_ff  <= 8'h00;
			post_ff <= 4'h0;
		end else begin
			pre_ff  <= (!t.on || inc) ? 4'h0 : (instr_en ? pre_ff + 4'h1 : pre_ff);
			cnt_ff  <= t.rollover ? 8'h00 : (inc ? cnt_ff + 8'h01 : cnt_ff);
			post_ff <= t.update_tick ? 4'h0 : (t.rollover ? post_ff + 4'h1 : post_ff);
		end
	end

	// Helper: pclk cycles between rollovers while the config holds still
	logic [15:0] per_cnt_ff;
	logic        per_ok_ff;
	logic [15:0] per_exp;
	assign per_exp = 16'(({8'h00, t.limit} + 16'h0001) * 16'(`ECPWM_INSTR_TOSC)
	                 * 16'(pre_last + 4'h1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			per_cnt_ff <= 16'h0000;
			per_ok_ff  <= 1'b0;
		end else begin
			per_cnt_ff <= t.rollover ? 16'h0000 : per_cnt_ff + 16'h0001;
			per_ok_ff  <= t.rollover ? 1'b1 :
			              (per_ok_ff & t.on & $stable(t.limit) & $stable(t.prescale));
		end
	end
	a_period_len: assert property (@(posedge pclk) disable iff (!presetn)
		t.rollover && per_ok_ff && $stable(t.limit) |-> per_cnt_ff + 16'h0001 == per_exp)
		else $error("period length differs from limit, prescale and 4 Tosc");
endmodule

// ===== hdl/ecpwm_out_stage.sv
// Maps the modulated signal onto outputs A-D by output config and polarity
`timescale 1ns/1ps
module ecpwm_out_stage
	import ecpwm_pkg::*;
(
	input  wire logic        mod,     // Modulated PWM level
	input  wire logic        db_ok,   // Dead-band delay elapsed
	input  wire logic        running, // PWM has seen its first period reset
	input  wire ecpwm_ocfg_e ocfg,    // Buffered output config
	input  wire logic [1:0]  pol,     // Bit 1: A,C active low; bit 0: B,D active low
	output logic      [3:0]  lvl      // Pin levels D..A
);
	logic [3:0] act;
	// Active-state view before polarity, all inactive until the first reset
	assign act[0] = running & ((ocfg == ECPWM_SINGLE) ? mod :
	                           (ocfg == ECPWM_HALF) ? (mod & db_ok) :
	                           (ocfg == ECPWM_FULL_FWD));
	assign act[1] = running & ((ocfg == ECPWM_HALF) ? (~mod & db_ok) :
	                           (ocfg == ECPWM_FULL_REV) & mod);
	assign act[2] = running & (ocfg == ECPWM_FULL_REV);
	assign act[3] = running & (ocfg == ECPWM_FULL_FWD) & mod;
	assign lvl = act ^ {pol[0], pol[1], pol[0], pol[1]};
endmodule

// ===== hdl/ecpwm_unit.sv
// Enhanced compare/PWM unit with APB register access
`timescale 1ns/1ps
`include "ecpwm_regs.svh"
module ecpwm_unit
	import ecpwm_pkg::*;
#(
	parameter int UNIT_NUM = 1 // Unit number 1..5; selects trigger and override wiring
) (
	input  wire logic        pclk,              // Oscillator clock, 10 MHz
	input  wire logic        presetn,           // Async reset, active low
	input  wire logic [7:0]  paddr,             // APB byte address
	input  wire logic        psel,              // APB select
	input  wire logic        penable,           // APB access phase
	input  wire logic        pwrite,            // APB write
	input  wire logic [31:0] pwdata,            // APB write data
	output logic      [31:0] prdata,            // APB read data
	output logic             pready,            // APB ready
	output logic             pslverr,           // APB error on unmapped address
	input  wire logic [15:0] timer_one_count,   // Timer one value
	input  wire logic [15:0] timer_three_count, // Timer three value
	input  wire logic        adc_enable,        // Converter module enabled
	input  wire logic        unit4_pin_in,      // Compare unit four's own pin level
	output logic             timer_one_reset,   // Pulse: clear timer one
	output logic             timer_three_reset, // Pulse: clear timer three
	output logic             adc_start,         // Pulse: start a conversion
	output logic             pwm_out_a,         // Output A
	output logic             pwm_out_b,         // Output B
	output logic             pwm_out_c,         // Output C
	output logic             pwm_out_d,         // Output D
	output logic             unit4_pin_out,     // Pin shared with compare unit four
	output logic             period_update_tick // Postscaled period tick
);
	// Instruction-cycle divider: one enable every 4 Tosc
	logic [1:0] ph_ff;
	logic       instr_en;
	assign instr_en = (ph_ff == `ECPWM_DIV_LAST);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ph_ff <= 2'h0;
		else          ph_ff <= ph_ff + 2'h1;
	end

	// Software registers
	logic [7:0]  ctrl_ff;
	logic [7:0]  duty_master_ff;
	logic [15:0] cmp_pair_ff;
	logic [6:0]  db_master_ff;
	logic [14:0] t2cfg_ff;
	logic [14:0] t4cfg_ff;
	logic [1:0]  tsel_ff;
	logic        cmp_flag_ff;

	logic wr;
	logic hit;
	logic w_ctrl, w_duty, w_cmp, w_db, w_t2, w_t4, w_tsel, w_stat;
	assign pready = 1'b1;
	assign wr = psel & penable & pwrite;
	assign hit = (paddr == `ECPWM_OFF_CTRL) | (paddr == `ECPWM_OFF_DUTY) |
	             (paddr == `ECPWM_OFF_DSLV) | (paddr == `ECPWM_OFF_CMP) |
	             (paddr == `ECPWM_OFF_DB) | (paddr == `ECPWM_OFF_T2CFG) |
	             (paddr == `ECPWM_OFF_T4CFG) | (paddr == `ECPWM_OFF_TSEL) |
	             (paddr == `ECPWM_OFF_STAT);
	assign pslverr = psel & penable & ~hit;
	assign w_ctrl = wr & (paddr == `ECPWM_OFF_CTRL);
	assign w_duty = wr & (paddr == `ECPWM_OFF_DUTY);
	assign w_cmp  = wr & (paddr == `ECPWM_OFF_CMP);
	assign w_db   = wr & (paddr == `ECPWM_OFF_DB);
	assign w_t2   = wr & (paddr == `ECPWM_OFF_T2CFG);
	assign w_t4   = wr & (paddr == `ECPWM_OFF_T4CFG);
	assign w_tsel = wr & (paddr == `ECPWM_OFF_TSEL);
	assign w_stat = wr & (paddr == `ECPWM_OFF_STAT);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_ff        <= `ECPWM_RST_BYTE;
			duty_master_ff <= `ECPWM_RST_BYTE;
			cmp_pair_ff    <= {`ECPWM_RST_BYTE, `ECPWM_RST_BYTE};
			db_master_ff   <= 7'h00;
			t2cfg_ff       <= `ECPWM_RST_TCFG;
			t4cfg_ff       <= `ECPWM_RST_TCFG;
			tsel_ff        <= 2'h0;
		end else begin
			if (w_ctrl) ctrl_ff <= pwdata[7:0];
			if (w_duty) duty_master_ff <= pwdata[7:0];
			if (w_cmp)  cmp_pair_ff <= pwdata[15:0];
			if (w_db)   db_master_ff <= pwdata[6:0];
			if (w_t2)   t2cfg_ff <= pwdata[14:0];
			if (w_t4)   t4cfg_ff <= pwdata[14:0];
			if (w_tsel) tsel_ff <= pwdata[1:0];
		end
	end

	// Period timers two and four
	ecpwm_tmr_if t2_if ();
	ecpwm_tmr_if t4_if ();
	assign t2_if.limit     = t2cfg_ff[7:0];
	assign t2_if.prescale  = t2cfg_ff[`ECPWM_TCFG_PRE_LSB +: 2];
	assign t2_if.on        = t2cfg_ff[`ECPWM_TCFG_ON_BIT];
	assign t2_if.postscale = t2cfg_ff[`ECPWM_TCFG_POST_LSB +: 4];
	assign t4_if.limit     = t4cfg_ff[7:0];
	assign t4_if.prescale  = t4cfg_ff[`ECPWM_TCFG_PRE_LSB +: 2];
	assign t4_if.on        = t4cfg_ff[`ECPWM_TCFG_ON_BIT];
	assign t4_if.postscale = t4cfg_ff[`ECPWM_TCFG_POST_LSB +: 4];
	ecpwm_period_timer u_t2 (
		.pclk     (pclk),
		.presetn  (presetn),
		.instr_en (instr_en),
		.ph       (ph_ff),
		.t        (t2_if.tmr)
	);
	ecpwm_period_timer u_t4 (
		.pclk     (pclk),
		.presetn  (presetn),
		.instr_en (instr_en),
		.ph       (ph_ff),
		.t        (t4_if.tmr)
	);

	logic       use_t4;
	logic       roll;
	logic [9:0] cnt10;
	logic [7:0] sel_limit;
	assign use_t4    = tsel_ff[`ECPWM_TSEL_PWM_BIT];
	assign roll      = use_t4 ? t4_if.rollover : t2_if.rollover;
	assign cnt10     = use_t4 ? {t4_if.count, t4_if.sub} : {t2_if.count, t2_if.sub};
	assign sel_limit = use_t4 ? t4_if.limit : t2_if.limit;

	// Compare and special event trigger
	logic        pwm_mode, cmp_mode, sevt_sel;
	logic [15:0] cmp_timer;
	logic        match, match_d_ff, cmp_evt, sevt;
	assign pwm_mode  = (ctrl_ff[3:2] == `ECPWM_MODE_PWM);
	assign cmp_mode  = (ctrl_ff[3:2] == `ECPWM_MODE_CMP);
	assign sevt_sel  = (ctrl_ff[3:0] == `ECPWM_MODE_SEVT) && (UNIT_NUM < 3);
	assign cmp_timer = tsel_ff[`ECPWM_TSEL_CMP_BIT] ? timer_three_count : timer_one_count;
	assign match     = cmp_mode & (cmp_timer == cmp_pair_ff);
	assign cmp_evt   = match & ~match_d_ff;
	assign sevt      = cmp_evt & sevt_sel;

	logic cmp_pin_ff, t1_rst_ff, t3_rst_ff, adc_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_d_ff  <= 1'b0;
			cmp_pin_ff  <= 1'b0;
			cmp_flag_ff <= 1'b0;
			t1_rst_ff   <= 1'b0;
			t3_rst_ff   <= 1'b0;
			adc_ff      <= 1'b0;
		end else begin
			match_d_ff <= match;
			if (cmp_evt && ctrl_ff[3:0] == `ECPWM_MODE_CSET) cmp_pin_ff <= 1'b1;
			if (cmp_evt && ctrl_ff[3:0] == `ECPWM_MODE_CCLR) cmp_pin_ff <= 1'b0;
			// A match in the clearing cycle keeps the flag set; 1011 on unit 3 flags like 1010
			cmp_flag_ff <= cmp_evt | (cmp_flag_ff & ~(w_stat & pwdata[`ECPWM_STAT_FLAG_BIT]));
			// Reset pulses carry no overflow, so the timer's own flag stays untouched
			t1_rst_ff <= sevt & ~tsel_ff[`ECPWM_TSEL_CMP_BIT];
			t3_rst_ff <= sevt & tsel_ff[`ECPWM_TSEL_CMP_BIT];
			adc_ff    <= sevt & (UNIT_NUM == 2) & adc_enable;
		end
	end
	assign timer_one_reset   = t1_rst_ff;
	assign timer_three_reset = t3_rst_ff;
	assign adc_start         = adc_ff;

	// Buffered PWM state
	ecpwm_ocfg_e ocfg_ff;
	logic [1:0]  pol_ff;
	logic [9:0]  duty_slave_ff;
	logic [9:0]  duty_next;
	logic [6:0]  db_act_ff;
	logic [6:0]  db_cnt_ff;
	logic        running_ff, mod_ff, mod_d_ff;
	logic        duty_hit, db_edge, db_ok, mod_lvl;
	assign duty_next = {duty_master_ff, ctrl_ff[`ECPWM_CTRL_DLO_LSB +: 2]};
	// Never true when duty exceeds the period, so the output then stays set
	assign duty_hit  = running_ff & (cnt10 == duty_slave_ff);
	// Level drops in the match cycle itself, so the duty spans whole clocks
	assign mod_lvl   = mod_ff & ~duty_hit;
	assign db_edge   = mod_lvl ^ mod_d_ff;
	assign db_ok     = (db_cnt_ff == 7'h00) & ~db_edge;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ocfg_ff       <= ECPWM_SINGLE;
			pol_ff        <= 2'h0;
			duty_slave_ff <= 10'h000;
			running_ff    <= 1'b0;
			mod_ff        <= 1'b0;
		end else if (!pwm_mode) begin
			running_ff <= 1'b0;
			mod_ff     <= 1'b0;
		end else if (roll) begin
			// Control and duty load only at the period reset
			ocfg_ff       <= ecpwm_ocfg_e'(ctrl_ff[`ECPWM_CTRL_OCFG_LSB +: 2]);
			pol_ff        <= ctrl_ff[1:0];
			duty_slave_ff <= duty_next;
			running_ff    <= 1'b1;
			mod_ff        <= (duty_next != 10'h000);
		end else if (duty_hit) begin
			mod_ff <= 1'b0;
		end
	end

	// Dead band counts instruction cycles from each edge of the modulated level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			db_act_ff <= 7'h00;
			db_cnt_ff <= 7'h00;
			mod_d_ff  <= 1'b0;
		end else begin
			mod_d_ff <= mod_lvl;
			if (roll || duty_hit) db_act_ff <= db_master_ff;
			if (db_edge)                          db_cnt_ff <= db_act_ff;
			else if (instr_en && db_cnt_ff != 7'h00) db_cnt_ff <= db_cnt_ff - 7'h01;
		end
	end

	logic [3:0] stage_lvl;
	ecpwm_out_stage u_out (
		.mod     (mod_lvl),
		.db_ok   (db_ok),
		.running (running_ff),
		.ocfg    (ocfg_ff),
		.pol     (pol_ff),
		.lvl     (stage_lvl)
	);

	// Pins are registered, so they follow the engine by one pclk
	logic [3:0] pins_ff;
	logic       u4_ff;
	logic       quad_over;
	assign quad_over = (UNIT_NUM == 3) & pwm_mode & ecpwm_is_quad(ocfg_ff);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_ff <= 4'h0;
			u4_ff   <= 1'b0;
		end else begin
			pins_ff <= pwm_mode ? stage_lvl : {3'h0, cmp_pin_ff};
			u4_ff   <= quad_over ? stage_lvl[3] : unit4_pin_in;
		end
	end
	assign pwm_out_a          = pins_ff[0];
	assign pwm_out_b          = pins_ff[1];
	assign pwm_out_c          = pins_ff[2];
	assign pwm_out_d          = pins_ff[3];
	assign unit4_pin_out      = u4_ff;
	assign period_update_tick = use_t4 ? t4_if.update_tick : t2_if.update_tick;

	// Read data is captured in the setup phase and held through the access phase
	logic [31:0] rd_word;
	assign rd_word =
		(paddr == `ECPWM_OFF_CTRL)  ? {24'h000000, ctrl_ff} :
		(paddr == `ECPWM_OFF_DUTY)  ? {24'h000000, duty_master_ff} :
		(paddr == `ECPWM_OFF_DSLV)  ? {22'h0, duty_slave_ff} :
		(paddr == `ECPWM_OFF_CMP)   ? {16'h0000, cmp_pair_ff} :
		(paddr == `ECPWM_OFF_DB)    ? {25'h0, db_master_ff} :
		(paddr == `ECPWM_OFF_T2CFG) ? {17'h0, t2cfg_ff} :
		(paddr == `ECPWM_OFF_T4CFG) ? {17'h0, t4cfg_ff} :
		(paddr == `ECPWM_OFF_TSEL)  ? {30'h0, tsel_ff} :
		(paddr == `ECPWM_OFF_STAT)  ? {22'h0, running_ff, cmp_flag_ff, cnt10[9:2]} :
		32'h00000000;
	logic [31:0] prdata_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)              prdata_ff <= 32'h00000000;
		else if (psel && !penable) prdata_ff <= rd_word;
	end
	assign prdata = prdata_ff;

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_sevt_mode_trig: assert property (
		cmp_evt && ctrl_ff[3:0] == `ECPWM_MODE_SEVT && UNIT_NUM < 3
		|=> timer_one_reset || timer_three_reset)
		else $error("special event trigger missing after compare match");
	a_sevt_reset_sel: assert property (
		timer_one_reset |-> !timer_three_reset && !$past(tsel_ff[`ECPWM_TSEL_CMP_BIT]))
		else $error("wrong timer reset by special event");
	a_adc_start: assert property (
		adc_start |-> UNIT_NUM == 2 && $past(adc_enable) && (timer_one_reset || timer_three_reset))
		else $error("conversion start without unit two trigger and enabled converter");
	a_no_sevt_high: assert property (
		UNIT_NUM >= 3 |-> !timer_one_reset && !timer_three_reset)
		else $error("unit without special event trigger reset a timer");
	a_flag_set_wins: assert property (
		cmp_evt |=> cmp_flag_ff)
		else $error("compare flag lost on match");
	a_cfg_buffered: assert property (
		pwm_mode && $past(pwm_mode) && !$past(roll) |-> $stable(ocfg_ff) && $stable(pol_ff)
		&& $stable(duty_slave_ff))
		else $error("buffered PWM control changed off the period boundary");
	a_duty_copy: assert property (
		pwm_mode && roll |=> duty_slave_ff == $past(duty_next) && mod_ff == ($past(duty_next) != 10'h000))
		else $error("duty not copied or output not set at period reset");
	a_db_load: assert property (
		pwm_mode && (roll || duty_hit) |=> db_act_ff == $past(db_master_ff))
		else $error("dead band not loaded at boundary");
	a_wait_start: assert property (
		!running_ff && pwm_mode |-> !mod_ff ##1 (pwm_out_a == $past(pol_ff[1])
		&& pwm_out_d == $past(pol_ff[0])))
		else $error("PWM active before its first period reset");
	a_over_duty: assert property (
		pwm_mode && mod_ff && !roll && duty_slave_ff > {sel_limit, 2'h3} |=> mod_ff)
		else $error("output cleared although duty exceeds period");
	a_quad_override: assert property (
		quad_over |=> unit4_pin_out == pwm_out_d)
		else $error("unit four pin not overridden in quad mode");

	c_pwm_cycle:  cover property (pwm_mode && roll && running_ff ##[1:300] duty_hit);
	c_sevt_adc:   cover property (adc_start);
	c_half_db:    cover property (running_ff && ocfg_ff == ECPWM_HALF && !db_ok);
	c_quad_pin:   cover property (quad_over && pwm_out_d);
endmodule

// ===== verif/ecpwm_timer_model.sv
// Behavioural model of the two free-running 16-bit compare timers
`timescale 1ns/1ps
module ecpwm_timer_model (
	input  wire logic        pclk,              // Oscillator clock
	input  wire logic        presetn,           // Async reset, active low
	input  wire logic        timer_one_reset,   // Clear request for timer one
	input  wire logic        timer_three_reset, // Clear request for timer three
	output logic      [15:0] timer_one_count,   // Timer one value
	output logic      [15:0] timer_three_count  // Timer three value
);
	// Counting on every clock keeps the match window one cycle wide
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_one_count   <= 16'h0000;
			timer_three_count <= 16'h0000;
		end else begin
			timer_one_count   <= timer_one_reset ? 16'h0000 : timer_one_count + 16'h0001;
			timer_three_count <= timer_three_reset ? 16'h0000 : timer_three_count + 16'h0001;
		end
	end
endmodule

// ===== verif/enhanced_compare_pwm_unit_tb_top.sv
// Self-checking bench: APB register access, special event trigger and PWM duty
`timescale 1ns/1ps
module enhanced_compare_pwm_unit_tb_top;
	import ecpwm_pkg::*;
	logic        pclk         = 1'b0;
	logic        presetn      = 1'b0;
	logic [7:0]  paddr        = 8'h00;
	logic        psel         = 1'b0;
	logic        penable      = 1'b0;
	logic        pwrite       = 1'b0;
	logic [31:0] pwdata       = 32'h0000_0000;
	logic        adc_enable   = 1'b1;
	logic        unit4_pin_in = 1'b0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] t1_cnt;
	logic [15:0] t3_cnt;
	logic        t1_rst;
	logic        t3_rst;
	logic        adc_start;
	logic [3:0]  pins;
	logic [31:0] rd;
	logic        err;
	logic [15:0] cmp;
	logic [9:0]  dv;
	logic        pol;
	logic        u4_out;
	logic        u4_prev;
	logic        tick;
	int          ticks;
	integer      num_errors   = 0;
	integer      n_compared   = 0;
	integer      seed         = 23714;
	int          n;
	int          cnt;
	int          exp_q[$];

	// Pins are plain outputs here; direction setup is the far side's job
	ecpwm_unit #(.UNIT_NUM(2)) u_ecpwm_unit (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_one_count(t1_cnt), .timer_three_count(t3_cnt), .adc_enable(adc_enable),
		.unit4_pin_in(unit4_pin_in), .timer_one_reset(t1_rst), .timer_three_reset(t3_rst),
		.adc_start(adc_start), .pwm_out_a(pins[0]), .pwm_out_b(pins[1]), .pwm_out_c(pins[2]),
		.pwm_out_d(pins[3]), .unit4_pin_out(u4_out), .period_update_tick(tick)
	);
	ecpwm_timer_model u_ecpwm_timer_model (
		.pclk(pclk), .presetn(presetn), .timer_one_reset(t1_rst),
		.timer_three_reset(t3_rst), .timer_one_count(t1_cnt), .timer_three_count(t3_cnt)
	);

	initial begin
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		unit4_pin_in <= $random(seed);
	end

	task give_verdict();
		$display("comparisons %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s: expected %0h seen %0h", name, exp, got);
		end
	endtask

	// Entered just after a rising edge; holds the request until pready is sampled
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int i;
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 20; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			num_errors++;
			give_verdict();
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_trig();
		for (n = 0; n < 300; n++) begin
			@(posedge pclk);
			if (t1_rst === 1'b1) break;
		end
		if (n == 300) begin
			num_errors++;
			give_verdict();
		end
	endtask

	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int a = 0; a <= 8'h20; a += 4) begin
			apb(a[7:0], 1'b0, 32'h0000_0000);
			check("reset value", 32'h0000_0000, rd);
		end
		apb(8'h24, 1'b0, 32'h0000_0000);
		check("unmapped error", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		// Timer one is near 40 when compare mode starts, so the match must lie above it
		cmp = 16'h0040 + ($random(seed) & 16'h001F);
		apb(8'h1C, 1'b1, 32'h0000_0000);
		apb(8'h0C, 1'b1, {16'h0000, cmp});
		apb(8'h00, 1'b1, 32'h0000_000B);
		wait_trig();
		check("count at trigger", {16'h0, cmp + 16'h1}, {16'h0, t1_cnt});
		check("conversion start", 32'h1, {31'h0, adc_start});
		adc_enable <= 1'b0;
		wait_trig();
		check("trigger spacing", cmp + 2, n + 1);
		check("start while disabled", 32'h0, {31'h0, adc_start});
		apb(8'h00, 1'b1, 32'h0000_0000);
		apb(8'h20, 1'b0, 32'h0000_0000);
		check("compare flag", 32'h1, {31'h0, rd[8]});
		apb(8'h20, 1'b1, 32'h0000_0100);
		apb(8'h20, 1'b0, 32'h0000_0000);
		check("flag cleared", 32'h0, {31'h0, rd[8]});
		// Limit 3, prescale 1: 16 clocks a period, so 64 clocks span four whole periods
		apb(8'h14, 1'b1, 32'h0000_0403);
		for (int k = 0; k < 6; k++) begin
			pol = k[0];
			dv = (k < 2) ? 10'h000 : (k < 4) ? ((($random(seed)) & 10'h00F) | 10'h001) : 10'h014;
			cnt = 4 * ((dv > 16) ? 16 : dv);
			exp_q.push_back(pol ? 64 - cnt : cnt);
			apb(8'h04, 1'b1, {24'h0, dv[9:2]});
			apb(8'h00, 1'b1, {24'h0, 2'b00, dv[1:0], 2'b11, pol, pol});
			// Buffered values only load at a rollover, so let two periods pass
			repeat (40) @(posedge pclk);
			cnt = 0;
			ticks = 0;
			u4_prev = unit4_pin_in;
			repeat (64) begin
				@(posedge pclk);
				cnt += (pins[0] === 1'b1);
				ticks += (tick === 1'b1);
				check("unit four pin", {31'h0, u4_prev}, {31'h0, u4_out});
				check("outputs B-D", {29'h0, {3{pol}}}, {29'h0, pins[3:1]});
				u4_prev = unit4_pin_in;
			end
			check("output A high clocks", exp_q.pop_front(), cnt);
			check("update ticks", 32'h4, ticks);
		end
		give_verdict();
	end
endmodule
